// ===== can_mode_defines.svh
// register offsets, field positions, reset values and thresholds of the mode/status block
// assumes: included by the design file, the checker and the bench by bare name
`ifndef CAN_MODE_DEFINES_SVH
`define CAN_MODE_DEFINES_SVH

`define OFF_CONTROL    12'h000
`define OFF_TEST       12'h004
`define OFF_ERRFLAGS   12'h008
`define OFF_STATUS     12'h00c
`define OFF_TIMESTAMP  12'h010
`define OFF_RXERR      12'h014
`define OFF_TXERR      12'h018

// control register fields
`define CTL_MODE_LO    0
`define CTL_MODE_HI    1
`define CTL_SLEEP      2
`define CTL_PRIO       3
`define CTL_IDF_LO     4
`define CTL_IDF_HI     5
`define CTL_TSRST      8
`define CTL_TSDIV_LO   9
`define CTL_TSDIV_HI   10

// error flag register fields
`define EF_BUSOFF      0
`define EF_WARN        1

// status register fields
`define ST_TX          0
`define ST_RX          1
`define ST_RESET       2
`define ST_HALT        3
`define ST_SLEEP       4
`define ST_PASSIVE     5
`define ST_BUSOFF      6

`define MODE_NORMAL    2'h0
`define MODE_RESET     2'h1
`define MODE_HALT      2'h2
`define MODE_FORCE     2'h3
`define IDF_STD        2'h0
`define IDF_EXT        2'h1
`define IDF_MIXED      2'h2
`define IDF_RESERVED   2'h3
`define TST_OFF        2'h0

`define TEC_BUSOFF     9'h100
`define ERR_WARN       9'h060
`define ERR_PASSIVE    9'h080
`define RECOV_SEQS     8'h80
`define RECOV_BITS     4'hb
`define NUM_MBOX       6'h20

`endif

// ===== can_mode_pkg.sv
// types shared by the mode/status block
// assumes: defines header available on the include path
package can_mode_pkg;
   typedef enum logic [1:0] {
      ST_NORMAL = 2'b00,
      ST_RESET = 2'b01,
      ST_HALT = 2'b10,
      ST_DRAIN = 2'b11
   } op_state_e;

   // status from the protocol engine
   typedef struct packed {
      logic transmitting;
      logic receiving;
      logic [8:0] tx_err_count;
      logic [7:0] rx_err_count;
      logic bit_tick;
      logic recessive_bit;
   } engine_status_s;

   // configuration handed to the protocol engine
   typedef struct packed {
      logic run;
      logic [1:0] test_mode_select;
      logic [1:0] id_format_mode;
      logic tx_priority_mode;
      logic busoff;
   } engine_config_s;
endpackage

// ===== can_mode_status_control.sv
// operating mode, configuration and status registers of one CAN channel, APB slave
// assumes: protocol engine runs on pclk and reports counters and activity each cycle;
// mailbox pending masks and identifiers arrive as flat vectors
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/100ps
`include "can_mode_defines.svh"
module can_mode_status_control (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire can_mode_pkg::engine_status_s eng,
   output can_mode_pkg::engine_config_s cfg,
   input wire logic [31:0] tx_pending,
   input wire logic [31:0] id_extension_bit,
   input wire logic [1023:0] mbox_ids,
   output logic tx_select_valid,
   output logic [4:0] tx_select_mbox,
   output logic [31:0] mbox_is_extended
);
   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic wr_en;
   logic mapped;
   assign wr_en = psel & penable & pwrite;
   assign pready = 1'b1;
   always_comb begin
      case (paddr)
         `OFF_CONTROL, `OFF_TEST, `OFF_ERRFLAGS, `OFF_STATUS,
         `OFF_TIMESTAMP, `OFF_RXERR, `OFF_TXERR: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~mapped;

   function automatic logic wr_hit(input logic [11:0] off);
      wr_hit = wr_en & (paddr == off);
   endfunction

   // ----------------------------------------------------------------
   // control and test registers
   // ----------------------------------------------------------------
   logic [1:0] op_mode_select_q;
   logic sleep_request_q;
   logic tx_priority_mode_q;
   logic [1:0] id_format_mode_q;
   logic [1:0] timestamp_prescale_select_q;
   logic [1:0] test_mode_select_q;
   logic ts_reset_pulse;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_mode_select_q <= `MODE_RESET;
         sleep_request_q <= 1'b1;
         tx_priority_mode_q <= 1'b0;
         id_format_mode_q <= `IDF_STD;
         timestamp_prescale_select_q <= 2'h0;
      end else if (wr_hit(`OFF_CONTROL)) begin
         op_mode_select_q <= pwdata[`CTL_MODE_HI:`CTL_MODE_LO];
         sleep_request_q <= pwdata[`CTL_SLEEP];
         tx_priority_mode_q <= pwdata[`CTL_PRIO];
         // the prohibited format code is refused; the old format stays
         if (pwdata[`CTL_IDF_HI:`CTL_IDF_LO] != `IDF_RESERVED) begin
            id_format_mode_q <= pwdata[`CTL_IDF_HI:`CTL_IDF_LO];
         end
         timestamp_prescale_select_q <= pwdata[`CTL_TSDIV_HI:`CTL_TSDIV_LO];
      end
   end
   // always_comb, not assign: the decode function reads bus signals that are not its arguments
   always_comb begin
      ts_reset_pulse = wr_hit(`OFF_CONTROL) & pwdata[`CTL_TSRST];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         test_mode_select_q <= `TST_OFF;
      end else if (wr_hit(`OFF_TEST)) begin
         test_mode_select_q <= pwdata[1:0];
      end
   end

   // ----------------------------------------------------------------
   // operating state
   // ----------------------------------------------------------------
   can_mode_pkg::op_state_e state_q;
   can_mode_pkg::op_state_e state_d;
   logic busoff_q;

   always_comb begin
      state_d = state_q;
      case (op_mode_select_q)
         `MODE_FORCE: state_d = can_mode_pkg::ST_RESET;
         `MODE_RESET: begin
            // a frame in flight is allowed to finish first
            if (eng.transmitting && state_q != can_mode_pkg::ST_RESET) begin
               state_d = can_mode_pkg::ST_DRAIN;
            end else begin
               state_d = can_mode_pkg::ST_RESET;
            end
         end
         `MODE_HALT: state_d = can_mode_pkg::ST_HALT;
         `MODE_NORMAL: state_d = can_mode_pkg::ST_NORMAL;
         default: state_d = can_mode_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= can_mode_pkg::ST_RESET;
      end else begin
         state_q <= state_d;
      end
   end

   logic in_reset;
   logic in_halt;
   logic in_sleep;
   assign in_reset = (state_q == can_mode_pkg::ST_RESET);
   assign in_halt = (state_q == can_mode_pkg::ST_HALT);
   // sleep is a plain register bit; this block has no wake-up on bus activity
   assign in_sleep = sleep_request_q;

   // ----------------------------------------------------------------
   // error state and bus-off recovery
   // ----------------------------------------------------------------
   logic [3:0] recess_run_q;
   logic [7:0] recov_seq_q;
   logic warn_level;
   logic passive_level;
   logic busoff_level;
   logic recov_done;

   assign warn_level = (eng.tx_err_count >= `ERR_WARN) ||
                       ({1'b0, eng.rx_err_count} >= `ERR_WARN);
   assign passive_level = (eng.tx_err_count >= `ERR_PASSIVE) ||
                          ({1'b0, eng.rx_err_count} >= `ERR_PASSIVE);
   assign busoff_level = (eng.tx_err_count >= `TEC_BUSOFF);
   // the last bit of the last run ends bus-off on the same tick
   assign recov_done = busoff_q && eng.bit_tick && eng.recessive_bit &&
                       (recess_run_q == `RECOV_BITS - 4'h1) &&
                       (recov_seq_q == `RECOV_SEQS - 8'h1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busoff_q <= 1'b0;
      end else if (in_reset) begin
         busoff_q <= 1'b0;
      end else if (busoff_level && !busoff_q) begin
         busoff_q <= 1'b1;
      end else if (recov_done) begin
         busoff_q <= 1'b0;
      end
   end

   // counts runs of eleven recessive bits while bus-off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         recess_run_q <= 4'h0;
         recov_seq_q <= 8'h00;
      end else if (!busoff_q) begin
         recess_run_q <= 4'h0;
         recov_seq_q <= 8'h00;
      end else if (eng.bit_tick) begin
         if (!eng.recessive_bit) begin
            recess_run_q <= 4'h0;
         end else if (recess_run_q == `RECOV_BITS - 4'h1) begin
            recess_run_q <= 4'h0;
            recov_seq_q <= recov_seq_q + 8'h01;
         end else begin
            recess_run_q <= recess_run_q + 4'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // sticky error cause flags
   // ----------------------------------------------------------------
   logic busoff_entry_flag_q;
   logic error_warning_flag_q;
   logic busoff_entry_ev;
   logic warn_prev_q;

   assign busoff_entry_ev = busoff_level && !busoff_q && !in_reset;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warn_prev_q <= 1'b0;
      end else begin
         warn_prev_q <= warn_level;
      end
   end

   // a set in the same cycle as a clearing write wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busoff_entry_flag_q <= 1'b0;
         error_warning_flag_q <= 1'b0;
      end else begin
         if (busoff_entry_ev) begin
            busoff_entry_flag_q <= 1'b1;
         end else if (wr_hit(`OFF_ERRFLAGS) && !pwdata[`EF_BUSOFF]) begin
            busoff_entry_flag_q <= 1'b0;
         end
         if (warn_level && !warn_prev_q) begin
            error_warning_flag_q <= 1'b1;
         end else if (wr_hit(`OFF_ERRFLAGS) && !pwdata[`EF_WARN]) begin
            error_warning_flag_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // timestamp counter
   // ----------------------------------------------------------------
   logic [15:0] timestamp_q;
   logic [2:0] ts_div_q;
   logic [2:0] ts_div_top;
   assign ts_div_top = (3'h1 << timestamp_prescale_select_q) - 3'h1;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timestamp_q <= 16'h0000;
         ts_div_q <= 3'h0;
      end else if (ts_reset_pulse || in_reset) begin
         timestamp_q <= 16'h0000;
         ts_div_q <= 3'h0;
      end else if (eng.bit_tick && !in_sleep) begin
         if (ts_div_q >= ts_div_top) begin
            ts_div_q <= 3'h0;
            timestamp_q <= timestamp_q + 16'h0001;
         end else begin
            ts_div_q <= ts_div_q + 3'h1;
         end
      end
   end

   // ----------------------------------------------------------------
   // transmit selection and identifier format
   // ----------------------------------------------------------------
   function automatic logic [28:0] mbox_id(input logic [4:0] idx);
      mbox_id = mbox_ids[idx * 32 +: 29];
   endfunction

   logic [4:0] best_c;
   logic found_c;
   always_comb begin
      best_c = 5'h00;
      found_c = 1'b0;
      for (int i = 0; i < 32; i++) begin
         if (tx_pending[i]) begin
            if (!found_c) begin
               best_c = 5'(i);
               found_c = 1'b1;
            end else if (!tx_priority_mode_q &&
                         mbox_id(5'(i)) < mbox_id(best_c)) begin
               best_c = 5'(i);
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_select_valid <= 1'b0;
         tx_select_mbox <= 5'h00;
      end else begin
         // lowest index wins ties; in number mode it always does
         // a pending mask change shows one edge later
         tx_select_valid <= found_c & (state_q == can_mode_pkg::ST_NORMAL);
         tx_select_mbox <= best_c;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mbox_is_extended <= 32'h00000000;
      end else begin
         case (id_format_mode_q)
            `IDF_EXT: mbox_is_extended <= 32'hffffffff;
            `IDF_MIXED: mbox_is_extended <= id_extension_bit;
            default: mbox_is_extended <= 32'h00000000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg <= '0;
      end else begin
         cfg.run <= (state_q == can_mode_pkg::ST_NORMAL ||
                     state_q == can_mode_pkg::ST_DRAIN) && !in_sleep;
         cfg.test_mode_select <= test_mode_select_q;
         cfg.id_format_mode <= id_format_mode_q;
         cfg.tx_priority_mode <= tx_priority_mode_q;
         cfg.busoff <= busoff_q;
      end
   end

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   logic [31:0] rd_c;
   always_comb begin
      rd_c = 32'h00000000;
      case (paddr)
         `OFF_CONTROL: begin
            rd_c[`CTL_MODE_HI:`CTL_MODE_LO] = op_mode_select_q;
            rd_c[`CTL_SLEEP] = sleep_request_q;
            rd_c[`CTL_PRIO] = tx_priority_mode_q;
            rd_c[`CTL_IDF_HI:`CTL_IDF_LO] = id_format_mode_q;
            rd_c[`CTL_TSDIV_HI:`CTL_TSDIV_LO] = timestamp_prescale_select_q;
         end
         `OFF_TEST: rd_c[1:0] = test_mode_select_q;
         `OFF_ERRFLAGS: begin
            rd_c[`EF_BUSOFF] = busoff_entry_flag_q;
            rd_c[`EF_WARN] = error_warning_flag_q;
         end
         `OFF_STATUS: begin
            rd_c[`ST_TX] = eng.transmitting | busoff_q;
            rd_c[`ST_RX] = eng.receiving & ~eng.transmitting;
            rd_c[`ST_RESET] = in_reset;
            rd_c[`ST_HALT] = in_halt;
            rd_c[`ST_SLEEP] = in_sleep;
            rd_c[`ST_PASSIVE] = passive_level & ~busoff_q;
            rd_c[`ST_BUSOFF] = busoff_q;
         end
         `OFF_TIMESTAMP: rd_c[15:0] = timestamp_q;
         `OFF_RXERR: rd_c[7:0] = eng.rx_err_count;
         `OFF_TXERR: rd_c[8:0] = eng.tx_err_count;
         default: rd_c = 32'h00000000;
      endcase
   end

   // read data registered in the setup cycle, valid during the access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (psel && !penable && !pwrite) begin
         prdata <= rd_c;
      end
   end
endmodule

// ===== can_engine_model.sv
// partner model: protocol engine status seen by the mode block
// assumes: bench sets counters and bus activity levels directly
`timescale 1ns/100ps
module can_engine_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tick_en,
   input wire logic [8:0] tec,
   input wire logic [7:0] rec,
   input wire logic tx_on,
   input wire logic rx_on,
   input wire logic idle_line,
   output can_mode_pkg::engine_status_s eng
);
   logic [1:0] div_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) div_q <= 2'h0;
      else div_q <= div_q + 2'h1;
   end
   // one bit time per 4 clocks; the level means nothing between ticks
   always_comb begin
      eng.transmitting = tx_on;
      eng.receiving = rx_on;
      eng.tx_err_count = tec;
      eng.rx_err_count = rec;
      eng.bit_tick = tick_en && (div_q == 2'h3);
      eng.recessive_bit = eng.bit_tick ? idle_line : div_q[0];
   end
endmodule

// ===== can_mode_status_control_chk.sv
// port assertions of the mode/status block
// assumes: bound to every instance of the block
`timescale 1ns/100ps
`include "can_mode_defines.svh"
module can_mode_status_control_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire can_mode_pkg::engine_status_s eng,
   input wire can_mode_pkg::engine_config_s cfg,
   input wire logic [31:0] id_extension_bit,
   input wire logic [31:0] mbox_is_extended
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr_ctl;
   logic wr_tst;
   assign wr_ctl = psel && penable && pwrite && paddr == `OFF_CONTROL;
   assign wr_tst = psel && penable && pwrite && paddr == `OFF_TEST;
   property p_normal;
      wr_ctl && pwdata[2:0] == 3'h0 && !eng.transmitting && !cfg.busoff |-> ##3 cfg.run;
   endproperty
   a_normal: assert property (p_normal) else $error("not running after normal");
   property p_halt;
      wr_ctl && pwdata[1:0] == 2'h2 |-> ##3 !cfg.run;
   endproperty
   a_halt: assert property (p_halt) else $error("running in halt");
   property p_force;
      wr_ctl && pwdata[1:0] == 2'h3 |-> ##3 !cfg.run;
   endproperty
   a_force: assert property (p_force) else $error("forced reset late");
   property p_busoff;
      $rose(eng.tx_err_count >= 9'h100) |-> ##[1:2] cfg.busoff;
   endproperty
   a_busoff: assert property (p_busoff) else $error("bus-off not entered");
   property p_idf;
      wr_ctl && pwdata[5:4] != 2'h3 |-> ##2 cfg.id_format_mode == $past(pwdata[5:4], 2);
   endproperty
   a_idf: assert property (p_idf) else $error("id format not taken");
   property p_idf_keep;
      wr_ctl && pwdata[5:4] == 2'h3 |-> ##2 cfg.id_format_mode == $past(cfg.id_format_mode, 2);
   endproperty
   a_idf_keep: assert property (p_idf_keep) else $error("id format 11 taken");
   property p_prio;
      wr_ctl |-> ##2 cfg.tx_priority_mode == $past(pwdata[3], 2);
   endproperty
   a_prio: assert property (p_prio) else $error("priority mode not taken");
   property p_test;
      wr_tst |-> ##2 cfg.test_mode_select == $past(pwdata[1:0], 2);
   endproperty
   a_test: assert property (p_test) else $error("test mode not taken");
   property p_mixed;
      cfg.id_format_mode == 2'h2 && $past(cfg.id_format_mode) == 2'h2 && $stable(id_extension_bit)
         |-> mbox_is_extended == id_extension_bit;
   endproperty
   a_mixed: assert property (p_mixed) else $error("mixed ext bits wrong");
   property p_err;
      pslverr |-> psel && penable;
   endproperty
   a_err: assert property (p_err) else $error("error outside access");
   c_force: cover property (wr_ctl && pwdata[1:0] == 2'h3 && eng.transmitting);
   c_busoff: cover property ($rose(cfg.busoff));
   c_mixed: cover property (cfg.id_format_mode == 2'h2);
endmodule
bind can_mode_status_control can_mode_status_control_chk chk_u (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pslverr(pslverr), .eng(eng), .cfg(cfg), .id_extension_bit(id_extension_bit),
   .mbox_is_extended(mbox_is_extended));

// ===== test_can_mode_status_control.sv
// self-checking bench for the mode/status block
// assumes: package, defines, design, engine model and checker compiled first
`timescale 1ns/100ps
`include "can_mode_defines.svh"
module test_can_mode_status_control;
   typedef struct {logic [11:0] a; logic [31:0] e; logic [31:0] m; logic err;} note_s;
   note_s q[$];
   typedef struct {int k; logic [31:0] e;} pick_s;
   pick_s cq[$];
   string nm [3] = '{"extended flags", "chosen mailbox", "selection valid"};
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic tick_en, tx_on, rx_on, idle_line, sel_v, look;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, pend, ext, xext;
   logic [8:0] tec;
   logic [7:0] rec;
   logic [4:0] sel_m;
   logic [1023:0] ids;
   can_mode_pkg::engine_status_s eng;
   can_mode_pkg::engine_config_s cfg;
   int n_fail = 0;
   int samples_checked = 0;
   logic [31:0] ctl_v [4] = '{32'h005, 32'h001, 32'h000, 32'h002};
   logic [31:0] st_v [4] = '{32'h014, 32'h004, 32'h000, 32'h008};
   can_mode_status_control dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .eng(eng), .cfg(cfg), .tx_pending(pend),
      .id_extension_bit(ext), .mbox_ids(ids), .tx_select_valid(sel_v),
      .tx_select_mbox(sel_m), .mbox_is_extended(xext));
   can_engine_model eng_u (.pclk(pclk), .presetn(presetn), .tick_en(tick_en), .tec(tec),
      .rec(rec), .tx_on(tx_on), .rx_on(rx_on), .idle_line(idle_line), .eng(eng));
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // apb master: hold the request until pready is seen, then release
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin n_fail++; report_and_stop(); end
      psel <= 1'b0; penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic err);
      q.push_back('{a, e, m, err});
      apb(1'b0, a, 32'h0);
   endtask
   // direct output checks, compared by the monitor below: 0 ext flags, 1 mailbox, 2 valid
   task automatic chk(input int k, input logic [31:0] e);
      cq.push_back('{k, e});
      look <= 1'b1;
      @(posedge pclk);
      look <= 1'b0;
      @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      pick_s y;
      logic [31:0] s;
      if (look && cq.size() > 0) begin
         y = cq.pop_front();
         s = y.k == 0 ? xext : y.k == 1 ? {27'h0, sel_m} : {31'h0, sel_v};
         samples_checked++;
         if (s !== y.e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm[y.k], y.e, s);
         end
      end
   end
   // read monitor: compares against the oldest note
   always @(posedge pclk) begin
      note_s x;
      if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0) begin
         x = q.pop_front();
         samples_checked++;
         if ((prdata & x.m) !== x.e || pslverr !== x.err) begin
            n_fail++;
            $display("Error reg %h expected %h seen %h", x.a, x.e, prdata & x.m);
         end
      end
   end
   initial begin
      cyc(100000);
      n_fail++;
      report_and_stop();
   end
   initial begin
      int i, j, b;
      logic [31:0] c;
      psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; presetn = 0;
      tick_en = 0; tx_on = 0; rx_on = 0; idle_line = 0; tec = 0; rec = 0;
      pend = 0; ext = 0; ids = 0; look = 0;
      c = $urandom(32'h82c26036);
      cyc(8);
      presetn <= 1'b1;
      cyc(1);
      rd(`OFF_CONTROL, 32'h005, 32'h7ff, 0);
      rd(`OFF_STATUS, 32'h014, 32'h7f, 0);
      rd(`OFF_ERRFLAGS, 0, 3, 0);
      rd(12'h01c, 0, 32'hffffffff, 1);
      for (i = 0; i < 4; i++) begin
         wr(`OFF_CONTROL, ctl_v[i]);
         cyc(3);
         rd(`OFF_STATUS, st_v[i], 32'h7f, 0);
      end
      $display("modes done");
      for (i = 0; i < 8; i++) begin
         c = {21'h0, 2'($urandom % 4), 3'h0, 2'($urandom % 3), 1'($urandom), 3'h0};
         wr(`OFF_CONTROL, c);
         rd(`OFF_CONTROL, c, 32'h7ff, 0);
         j = $urandom % 4;
         wr(`OFF_TEST, 32'(j));
         rd(`OFF_TEST, 32'(j), 3, 0);
      end
      wr(`OFF_CONTROL, c | 32'h30);
      rd(`OFF_CONTROL, c, 32'h7ff, 0);
      wr(`OFF_TEST, 0);
      $display("config done");
      tx_on <= 1'b1;
      wr(`OFF_CONTROL, 32'h001);
      cyc(3);
      rd(`OFF_STATUS, 32'h001, 32'h7f, 0);
      tx_on <= 1'b0;
      cyc(3);
      rd(`OFF_STATUS, 32'h004, 32'h7f, 0);
      wr(`OFF_CONTROL, 32'h000);
      tx_on <= 1'b1;
      wr(`OFF_CONTROL, 32'h003);
      cyc(3);
      rd(`OFF_STATUS, 32'h005, 32'h7f, 0);
      tx_on <= 1'b0;
      wr(`OFF_CONTROL, 32'h000);
      rx_on <= 1'b1;
      cyc(3);
      rd(`OFF_STATUS, 32'h002, 32'h7f, 0);
      rx_on <= 1'b0;
      $display("modes under traffic done");
      rec <= 8'd96;
      cyc(3);
      rd(`OFF_ERRFLAGS, 2, 3, 0);
      wr(`OFF_ERRFLAGS, 2);
      rd(`OFF_ERRFLAGS, 2, 3, 0);
      wr(`OFF_ERRFLAGS, 0);
      rd(`OFF_ERRFLAGS, 0, 3, 0);
      rec <= 8'd128;
      cyc(3);
      rd(`OFF_STATUS, 32'h020, 32'h7f, 0);
      rd(`OFF_RXERR, 128, 32'hff, 0);
      c = $urandom % 256;
      tec <= c[8:0];
      cyc(2);
      rd(`OFF_TXERR, c, 32'h1ff, 0);
      // the warning condition stays true across this step, so no new warning
      tec <= 9'h100;
      rec <= 8'd0;
      cyc(3);
      rd(`OFF_ERRFLAGS, 1, 3, 0);
      rd(`OFF_STATUS, 32'h041, 32'h7f, 0);
      wr(`OFF_ERRFLAGS, 1);
      rd(`OFF_ERRFLAGS, 1, 3, 0);
      wr(`OFF_ERRFLAGS, 0);
      rd(`OFF_ERRFLAGS, 0, 3, 0);
      tec <= 9'h0;
      idle_line <= 1'b1;
      tick_en <= 1'b1;
      cyc(5300);
      rd(`OFF_STATUS, 32'h040, 32'h40, 0);
      cyc(400);
      rd(`OFF_STATUS, 32'h000, 32'h7f, 0);
      tick_en <= 1'b0;
      $display("errors done");
      for (i = 0; i < 4; i++) begin
         wr(`OFF_CONTROL, 32'h100 | 32'(i << 9));
         rd(`OFF_TIMESTAMP, 0, 32'hffff, 0);
         tick_en <= 1'b1;
         cyc(64);
         tick_en <= 1'b0;
         rd(`OFF_TIMESTAMP, 32'(16 >> i), 32'hffff, 0);
      end
      $display("timestamp done");
      for (i = 0; i < 3; i++) begin
         wr(`OFF_CONTROL, 32'(i << 4));
         ext <= $urandom;
         cyc(4);
         chk(0, i == 0 ? 32'h0 : i == 1 ? 32'hffffffff : ext);
      end
      for (i = 0; i < 8; i++) begin
         wr(`OFF_CONTROL, i[0] ? 32'h008 : 32'h000);
         pend <= $urandom | 32'h1 << ($urandom % 32);
         for (j = 0; j < 32; j++) ids[32 * j +: 32] <= $urandom;
         cyc(4);
         b = -1;
         for (j = 0; j < 32; j++)
            if (pend[j] && (b < 0 || (!i[0] && ids[32 * j +: 29] < ids[32 * b +: 29]))) b = j;
         chk(1, 32'(b));
         chk(2, 32'h1);
      end
      $display("mailbox done");
      cyc(2);
      report_and_stop();
   end
endmodule
